// File: src/dsr_diag_status.sv
// Diagnostic status bank: global status and overcurrent of bridges 1-8.
// Assumes a serial shifter that hands over one decoded address byte per
// frame and sends back the returned data byte in that frame.
`timescale 1ns/1ns
module dsr_diag_status (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Frame from the serial shifter
   input wire dsr_pkg::dsr_access_t access,
   output dsr_pkg::dsr_resp_t resp,
   // Fault detectors
   input wire dsr_pkg::dsr_fault_t faultDetect,
   input wire logic powerOnResetEvent,
   input wire logic [15:0] overcurrentDetect,
   input wire logic [15:0] openLoadFlags,
   // Power stage control
   output logic allOutputsOff,
   output logic [15:0] sideOff,
   // Status view
   output logic loadFaultSummary,
   output logic [7:0] globalStatus
);

   dsr_pkg::dsr_state_t state_reg;
   dsr_pkg::dsr_state_t state_next;

   logic [7:0] bridge14Flags;
   logic [7:0] bridge58Flags;
   logic [2:0] selCode;
   logic frameShapeOk;
   logic hitGlobal;
   logic hitBridge14;
   logic hitBridge58;
   logic clearAccess;
   logic clearGlobal;
   logic clearBridge14;
   logic clearBridge58;
   logic [7:0] readValue;
   logic [7:0] globalView;
   logic loadSummary;

   ////////////////////////////////////////////////////////////////////////
   // Address decoding

   assign selCode = access.addr[dsr_pkg::SEL_MSB:dsr_pkg::SEL_LSB];
   // Tail bit is a don't care for these registers
   assign frameShapeOk =
      (access.addr[dsr_pkg::FIXED_MSB:dsr_pkg::FIXED_LSB] ==
       dsr_pkg::ADDR_FIXED_CODE) &&
      (access.addr[dsr_pkg::ADDRESS_END_BIT] == dsr_pkg::ADDR_END_CODE);

   always_comb begin
      hitGlobal = 1'b0;
      hitBridge14 = 1'b0;
      hitBridge58 = 1'b0;
      if (!access.valid || !frameShapeOk) begin
         hitGlobal = 1'b0;
      end else if (selCode == dsr_pkg::SEL_GLOBAL_STATUS) begin
         hitGlobal = 1'b1;
      end else if (selCode == dsr_pkg::SEL_BRIDGES_1_4) begin
         hitBridge14 = 1'b1;
      end else if (selCode == dsr_pkg::SEL_BRIDGES_5_8) begin
         hitBridge58 = 1'b1;
      end
   end

   // Only a frame with the access kind bit set clears
   assign clearAccess = access.addr[dsr_pkg::ACCESS_KIND_BIT];
   // Each clear reaches only the register it addresses
   assign clearGlobal = hitGlobal && clearAccess;
   assign clearBridge14 = hitBridge14 && clearAccess;
   assign clearBridge58 = hitBridge58 && clearAccess;

   ////////////////////////////////////////////////////////////////////////
   // Overcurrent flag banks, bridge n at bits 2n-1 (high) and 2n-2 (low)

   dsr_flag_bank bank14 (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .setEvent(overcurrentDetect[7:0]),
      .clearEn(clearBridge14),
      .flags(bridge14Flags)
   );

   dsr_flag_bank bank58 (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .setEvent(overcurrentDetect[15:8]),
      .clearEn(clearBridge58),
      .flags(bridge58Flags)
   );

   ////////////////////////////////////////////////////////////////////////
   // Global status view

   // Pure OR of live flags, so it drops once every flag is cleared
   assign loadSummary = (|bridge14Flags) || (|bridge58Flags) ||
                        (|openLoadFlags);

   always_comb begin
      globalView = dsr_pkg::STATUS_RESET;
      globalView[dsr_pkg::GS_PROTOCOL_BIT] =
         state_reg.flags.protocolErrorFlag;
      globalView[dsr_pkg::GS_LOAD_SUMMARY_BIT] = loadSummary;
      globalView[dsr_pkg::GS_SUPPLY_LOW_BIT] =
         state_reg.flags.supplyLowFault;
      globalView[dsr_pkg::GS_SUPPLY_HIGH_BIT] =
         state_reg.flags.supplyHighFault;
      globalView[dsr_pkg::GS_RESET_ABSENT_BIT] =
         state_reg.flags.supplyResetAbsentFlag;
      globalView[dsr_pkg::GS_THERMAL_SHUTDOWN_BIT] =
         state_reg.flags.thermalShutdownFlag;
      globalView[dsr_pkg::GS_THERMAL_WARNING_BIT] =
         state_reg.flags.thermalWarningFlag;
      globalView[dsr_pkg::GS_RESERVED_BIT] = 1'h0;
   end

   always_comb begin
      readValue = dsr_pkg::STATUS_RESET;
      if (hitGlobal) begin
         readValue = globalView;
      end else if (hitBridge14) begin
         readValue = bridge14Flags;
      end else if (hitBridge58) begin
         readValue = bridge58Flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      state_next = state_reg;
      // Data byte holds the value from before any clear
      state_next.resp.valid = access.valid;
      state_next.resp.data = access.valid ? readValue : state_reg.resp.data;

      // Flags hold until the host clears them
      if (clearGlobal) begin
         // Set wins, so a persisting fault shows again at once
         state_next.flags.protocolErrorFlag =
            faultDetect.protocolError;
         state_next.flags.supplyLowFault =
            faultDetect.supplyLow;
         state_next.flags.supplyHighFault =
            faultDetect.supplyHigh;
         state_next.flags.thermalShutdownFlag =
            faultDetect.thermalShutdown;
         state_next.flags.thermalWarningFlag =
            faultDetect.thermalWarning;
      end else begin
         state_next.flags.protocolErrorFlag =
            state_reg.flags.protocolErrorFlag ||
            faultDetect.protocolError;
         state_next.flags.supplyLowFault =
            state_reg.flags.supplyLowFault ||
            faultDetect.supplyLow;
         state_next.flags.supplyHighFault =
            state_reg.flags.supplyHighFault ||
            faultDetect.supplyHigh;
         state_next.flags.thermalShutdownFlag =
            state_reg.flags.thermalShutdownFlag ||
            faultDetect.thermalShutdown;
         state_next.flags.thermalWarningFlag =
            state_reg.flags.thermalWarningFlag ||
            faultDetect.thermalWarning;
      end

      // Reset-absent flag: a reset event forces zero, a clear re-arms it
      if (powerOnResetEvent) begin
         state_next.flags.supplyResetAbsentFlag = 1'h0;
      end else if (clearGlobal) begin
         state_next.flags.supplyResetAbsentFlag = 1'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg.flags <= '0;
         state_reg.resp.valid <= 1'b0;
         state_reg.resp.data <= dsr_pkg::STATUS_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign resp = state_reg.resp;
   // Thermal warning alone never shuts anything off
   // A latched supply low, supply high or thermal shutdown flag stops every output
   assign allOutputsOff = state_reg.flags.supplyLowFault ||
      state_reg.flags.supplyHighFault ||
      state_reg.flags.thermalShutdownFlag;
   assign sideOff = {bridge58Flags, bridge14Flags};
   assign loadFaultSummary = loadSummary;
   assign globalStatus = globalView;

endmodule

// File: src/dsr_pkg.sv
// Constants and carrier types of the diagnostic status register bank.
// Assumes one clock domain; all users write dsr_pkg::name.
package dsr_pkg;

   localparam int STATUS_WIDTH = 8;
   localparam int SIDE_COUNT = 16;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // Address byte layout
   localparam int ACCESS_KIND_BIT = 7;
   localparam int SEL_MSB = 6;
   localparam int SEL_LSB = 4;
   localparam int FIXED_MSB = 3;
   localparam int FIXED_LSB = 2;
   localparam int ADDRESS_TAIL_BIT = 1;
   localparam int ADDRESS_END_BIT = 0;
   localparam logic [1:0] ADDR_FIXED_CODE = 2'h2;
   localparam logic ADDR_END_CODE = 1'h1;
   localparam logic [2:0] SEL_GLOBAL_STATUS = 3'h1;
   localparam logic [2:0] SEL_BRIDGES_1_4 = 3'h5;
   localparam logic [2:0] SEL_BRIDGES_5_8 = 3'h3;

   // Global status field positions
   localparam int GS_PROTOCOL_BIT = 7;
   localparam int GS_LOAD_SUMMARY_BIT = 6;
   localparam int GS_SUPPLY_LOW_BIT = 5;
   localparam int GS_SUPPLY_HIGH_BIT = 4;
   localparam int GS_RESET_ABSENT_BIT = 3;
   localparam int GS_THERMAL_SHUTDOWN_BIT = 2;
   localparam int GS_THERMAL_WARNING_BIT = 1;
   localparam int GS_RESERVED_BIT = 0;

   // Fault detector levels, one cycle each or held while present
   typedef struct packed {
      logic protocolError;
      logic supplyLow;
      logic supplyHigh;
      logic thermalShutdown;
      logic thermalWarning;
   } dsr_fault_t;

   // Decoded frame from the serial shifter: address byte only
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
   } dsr_access_t;

   // Data byte returned for the frame
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } dsr_resp_t;

   // Stored global status flags
   typedef struct packed {
      logic protocolErrorFlag;
      logic supplyLowFault;
      logic supplyHighFault;
      logic supplyResetAbsentFlag;
      logic thermalShutdownFlag;
      logic thermalWarningFlag;
   } dsr_global_t;

   typedef struct packed {
      logic [7:0] bits;
   } dsr_bank_t;

   typedef struct packed {
      dsr_global_t flags;
      dsr_resp_t resp;
   } dsr_state_t;

endpackage

// File: src/dsr_flag_bank.sv
// One byte of read-clear sticky flags.
// Assumes setEvent and clearEn are synchronous to sys_clk.
`timescale 1ns/1ns
module dsr_flag_bank (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Events and clear
   input wire logic [7:0] setEvent,
   input wire logic clearEn,
   // Stored flags
   output logic [7:0] flags
);

   dsr_pkg::dsr_bank_t state_reg;
   dsr_pkg::dsr_bank_t state_next;

   always_comb begin
      state_next = state_reg;
      if (clearEn) begin
         // Set wins over clear; a present fault stays flagged
         state_next.bits = setEvent;
      end else begin
         state_next.bits = state_reg.bits | setEvent;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg.bits <= dsr_pkg::STATUS_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign flags = state_reg.bits;

endmodule

// File: verif/dsr_checker.sv
// Assertions on the status bank ports.
// Bound to dsr_diag_status; one clock, async low reset.
`timescale 1ns/1ns
module dsr_checker (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Frame
   input wire dsr_pkg::dsr_access_t access,
   input wire dsr_pkg::dsr_resp_t resp,
   // Fault sources
   input wire dsr_pkg::dsr_fault_t faultDetect,
   input wire logic powerOnResetEvent,
   input wire logic [15:0] overcurrentDetect,
   input wire logic [15:0] openLoadFlags,
   // Results
   input wire logic allOutputsOff,
   input wire logic [15:0] sideOff,
   input wire logic loadFaultSummary,
   input wire logic [7:0] globalStatus
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   property p_rsp; access.valid |=> resp.valid; endproperty
   a_rsp: assert property (p_rsp) else $error("no answer");
   property p_rsv; globalStatus[0] == 1'b0; endproperty
   a_rsv: assert property (p_rsv) else $error("bit0 set");
   property p_sum;
      loadFaultSummary == ((|sideOff) | (|openLoadFlags))
         && globalStatus[6] == loadFaultSummary;
   endproperty
   a_sum: assert property (p_sum) else $error("summary");
   property p_oc;
      |overcurrentDetect |=>
         (sideOff & $past(overcurrentDetect)) == $past(overcurrentDetect);
   endproperty
   a_oc: assert property (p_oc) else $error("side off");
   property p_uv;
      faultDetect.supplyLow |=> allOutputsOff && globalStatus[5];
   endproperty
   a_uv: assert property (p_uv) else $error("uv");
   property p_ov;
      faultDetect.supplyHigh |=> allOutputsOff && globalStatus[4];
   endproperty
   a_ov: assert property (p_ov) else $error("ov");
   property p_tsd;
      faultDetect.thermalShutdown |=> allOutputsOff && globalStatus[2];
   endproperty
   a_tsd: assert property (p_tsd) else $error("tsd");
   property p_pe; faultDetect.protocolError |=> globalStatus[7]; endproperty
   a_pe: assert property (p_pe) else $error("proto");
   property p_tpw;
      faultDetect == 5'h01 && !allOutputsOff |=>
         globalStatus[1] && !allOutputsOff;
   endproperty
   a_tpw: assert property (p_tpw) else $error("warn");
   property p_por; powerOnResetEvent |=> !globalStatus[3]; endproperty
   a_por: assert property (p_por) else $error("por");
   property p_keep;
      globalStatus[7] && !access.valid |=> globalStatus[7];
   endproperty
   a_keep: assert property (p_keep) else $error("lost flag");
   c_clr: cover property (access.valid && access.addr == 8'h99);
   c_oc: cover property (|sideOff);
   c_off: cover property (allOutputsOff);
endmodule
bind dsr_diag_status dsr_checker u_dsr_checker (
   .sys_clk(sys_clk), .resetn(resetn), .access(access), .resp(resp),
   .faultDetect(faultDetect), .powerOnResetEvent(powerOnResetEvent),
   .overcurrentDetect(overcurrentDetect), .openLoadFlags(openLoadFlags),
   .allOutputsOff(allOutputsOff), .sideOff(sideOff),
   .loadFaultSummary(loadFaultSummary), .globalStatus(globalStatus)
);

// File: verif/dsr_host_model.sv
// Host side: one frame per call, returns the answer byte.
// Assumes the bank answers one cycle after the request edge.
`timescale 1ns/1ns
module dsr_host_model (
   // Clock
   input wire logic sys_clk,
   // Frame
   output dsr_pkg::dsr_access_t access,
   input wire dsr_pkg::dsr_resp_t resp
);
   initial access = '0;
   // Address bit 7 picks read or read-clear; released address inverted
   task automatic frame(input logic [7:0] addr, output logic [7:0] data);
      @(posedge sys_clk);
      #1 access = {1'b1, addr};
      @(posedge sys_clk);
      #1 access = {1'b0, ~addr};
      data = resp.valid ? resp.data : 8'hXX;
   endtask
endmodule

// File: verif/tb_dsr_diag_status.sv
// Self-checking bench of the diagnostic status bank.
// Drives fault sources directly; frames come from the host model.
`timescale 1ns/1ns
module tb_dsr_diag_status;
   logic sys_clk;
   logic resetn;
   dsr_pkg::dsr_access_t access;
   dsr_pkg::dsr_resp_t resp;
   dsr_pkg::dsr_fault_t faultDetect;
   logic powerOnResetEvent;
   logic allOutputsOff;
   logic loadFaultSummary;
   logic [15:0] overcurrentDetect;
   logic [15:0] openLoadFlags;
   logic [15:0] sideOff;
   logic [7:0] globalStatus;
   logic [7:0] got;
   int badCount = 0;
   int checksDone = 0;
   dsr_diag_status u_dsr_diag_status (.sys_clk(sys_clk), .resetn(resetn),
      .access(access), .resp(resp), .faultDetect(faultDetect),
      .powerOnResetEvent(powerOnResetEvent),
      .overcurrentDetect(overcurrentDetect), .openLoadFlags(openLoadFlags),
      .allOutputsOff(allOutputsOff), .sideOff(sideOff),
      .loadFaultSummary(loadFaultSummary), .globalStatus(globalStatus));
   dsr_host_model u_dsr_host_model (.sys_clk(sys_clk), .access(access),
      .resp(resp));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checksDone++;
      if (seen !== exp) begin
         badCount++;
         $display("ERROR %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      u_dsr_host_model.frame(addr, got);
      chk(16'(got), 16'(exp));
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_reset();
      chk(sideOff, 16'h0000);
      rd(8'h19, 8'h00);
      rd(8'h5B, 8'h00);
      rd(8'h39, 8'h00);
      rd(8'h99, 8'h00);
      rd(8'h1B, 8'h08);
   endtask
   task automatic t_global();
      logic [7:0] m [5] = '{8'h80, 8'h20, 8'h10, 8'h04, 8'h02};
      for (int i = 0; i < 5; i++) begin
         @(posedge sys_clk);
         #1 faultDetect = 5'h10 >> i;
         @(posedge sys_clk);
         #1 faultDetect = '0;
         chk(16'(allOutputsOff), 16'(i inside {[1:3]}));
         rd(8'h19, m[i] | 8'h08);
         rd(8'h99, m[i] | 8'h08);
         rd(8'h19, 8'h08);
         chk(16'(allOutputsOff), 16'h0000);
      end
   endtask
   task automatic t_por();
      @(posedge sys_clk);
      #1 powerOnResetEvent = 1'b1;
      @(posedge sys_clk);
      #1 powerOnResetEvent = 1'b0;
      rd(8'h19, 8'h00);
      rd(8'h99, 8'h00);
   endtask
   task automatic t_oc();
      for (int k = 0; k < 16; k++) begin
         @(posedge sys_clk);
         #1 overcurrentDetect = 16'h0001 << k;
         @(posedge sys_clk);
         #1 overcurrentDetect = '0;
         chk(sideOff, 16'h0001 << k);
         chk(16'(globalStatus[6]), 16'h0001);
         rd(k < 8 ? 8'hB9 : 8'hD9, 8'h00);
         rd(k < 8 ? 8'hDB : 8'hBB, 8'h01 << (k % 8));
         rd(8'h19, 8'h08);
         chk(sideOff, 16'h0000);
      end
   endtask
   task automatic t_hold();
      @(posedge sys_clk);
      #1 faultDetect.thermalWarning = 1'b1;
      rd(8'h99, 8'h0A);
      rd(8'h19, 8'h0A);
      faultDetect = '0;
      rd(8'h9F, 8'h00);
      rd(8'h8B, 8'h00);
      rd(8'h19, 8'h0A);
      rd(8'h99, 8'h0A);
      rd(8'h19, 8'h08);
   endtask
   task automatic t_open();
      openLoadFlags = 16'h8000;
      #1;
      chk(16'(loadFaultSummary), 16'h0001);
      rd(8'h19, 8'h48);
      openLoadFlags = 16'h0000;
      rd(8'h19, 8'h08);
   endtask
   task automatic t_rst();
      @(posedge sys_clk);
      #1 overcurrentDetect = 16'h8000;
      faultDetect.supplyLow = 1'h1;
      @(posedge sys_clk);
      #1 overcurrentDetect = '0;
      faultDetect = '0;
      chk(16'(allOutputsOff), 16'h0001);
      resetn = 1'h0;
      @(posedge sys_clk);
      #1 resetn = 1'h1;
      chk(sideOff, 16'h0000);
      chk(16'(allOutputsOff), 16'h0000);
      rd(8'h19, 8'h00);
      rd(8'h3B, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      #100000;
      badCount++;
      tally_and_finish();
   end
   initial begin
      resetn = 1'b0;
      faultDetect = '0;
      powerOnResetEvent = 1'b0;
      overcurrentDetect = '0;
      openLoadFlags = '0;
      repeat (8) @(posedge sys_clk);
      #1 resetn = 1'b1;
      t_reset();
      t_global();
      t_por();
      t_oc();
      t_hold();
      t_open();
      t_rst();
      tally_and_finish();
   end
endmodule
